// ### rtl/tlbf_insert.sv
// Translation insert block: formats and installs entries, answers lookups.
// Assumes a single AHB-Lite master on clk_sys; hready is hreadyout looped back.
//
// What this block does
// - four insert kinds, each into its own structure
// - physical, attribute, permission fields from operand
// - virtual page from fault address bits 63:12
// - top address bits pick region, tag its identifier
// - region identifier matched like virtual page bits
// - reserved fields or encodings raise reserved fault
// - clear present flag gives not-present fault
// - operand bits 4:2 stored as memory attribute
// - clear accessed bit faults unless checking disabled
// - clear dirty bit faults stores; never set
// - bits 8:7 privilege, 11:9 access rights
// - bits 49:12 physical page, low bits ignored
// - software-available bits ignored on insert
// - deferral flag kept, ignored for data lookups
// - page size exponent from info bits 7:2
// - protection key stored; absent key faults
// - not-present insert keeps size, page, region only
// - remove overlapping same-side cache entries before installing
//
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
module tlbf_insert
  import tlbf_pkg::*;
#(
  parameter int NS = 2,
  parameter int NPKR = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  localparam int IW = (NS > 1) ? $clog2(NS) : 1;
  localparam int KW = (NPKR > 1) ? $clog2(NPKR) : 1;
  localparam int NE = NUM_STRUCT * NS;

  typedef struct packed {
    logic [31:0] grLo;
    logic [31:0] grHi;
    logic [31:0] iiLo;
    logic [31:0] iiHi;
    logic [31:0] faLo;
    logic [31:0] faHi;
    logic [31:0] lkLo;
    logic [31:0] lkHi;
    logic [31:0] lkRes;
    logic [31:0] lkPpn;
    logic [NUM_RR-1:0][31:0] rr;
    logic [1:0][IW-1:0] tcPtr;
    logic rsvdFault;
    logic wrPend;
    logic rdWait;
    logic [7:0] addr;
    logic [31:0] rdata;
  } tlbf_state_type;

  tlbf_state_type s_ff;
  tlbf_state_type nxt_s;

  logic [63:0] gr;
  logic [63:0] ii;
  logic [63:0] fa;
  logic [63:0] lk;
  logic [31:0] insRr;
  logic [23:0] newRid;
  logic [51:0] newVpn;
  logic [5:0] insPs;
  logic [23:0] lkRid;
  logic [51:0] lkVpn;
  logic rsvd;
  tlbf_entry_type newEntry;
  tlbf_entry_type ent [NE];
  logic [NE-1:0] ovl;
  logic [NE-1:0] hit;
  logic [NE-1:0] slotWr;
  logic [NE-1:0] slotClr;
  logic lkInstr;
  logic found;
  tlbf_entry_type fe;
  logic keyHit;
  logic [31:0] keyRd;
  logic keyWr;
  logic [37:0] pgMask;
  logic keyAddr;
  logic [2:0] cmdOp;
  logic cmdIns;
  logic cmdCache;
  logic cmdPurge;
  logic lkLegacy;
  logic lkChkOn;

  assign gr = {s_ff.grHi, s_ff.grLo};
  assign ii = {s_ff.iiHi, s_ff.iiLo};
  assign fa = {s_ff.faHi, s_ff.faLo};
  assign lk = {s_ff.lkHi, s_ff.lkLo};

  // Region identifier is copied into the entry, so later writes to the
  // region register leave installed entries alone
  assign insRr = s_ff.rr[fa[VA_VRN +: 3]];
  assign newRid = insRr[RR_RID +: 24];
  assign newVpn = fa[63:VA_VPN];
  assign insPs = ii[II_PS +: 6];
  // Lookups read the live region register; entries keep their own copy
  assign lkRid = s_ff.rr[lk[VA_VRN +: 3]][RR_RID +: 24];
  assign lkVpn = lk[63:VA_VPN];

  // Operand reserved bits only matter for a present entry
  assign rsvd = (ii[II_RSV +: 2] != '0) || (s_ff.iiHi != '0) || (insPs < PS_MIN) ||
                insRr[RR_RSV] || (gr[GR_P] && (gr[GR_RSV +: 2] != '0));

  always_comb begin
    newEntry = '0;
    // Hidden valid bit, kept apart from the present flag
    newEntry.valid = 1'b1;
    newEntry.present = gr[GR_P];
    newEntry.ps = insPs;
    newEntry.vpn = newVpn;
    newEntry.rid = newRid;
    // Absent pages carry only size, page and region
    if (gr[GR_P]) begin
      newEntry.ma = gr[GR_MA +: 3];
      newEntry.a = gr[GR_A];
      newEntry.d = gr[GR_D];
      newEntry.pl = gr[GR_PL +: 2];
      newEntry.ar = gr[GR_AR +: 3];
      newEntry.ppn = gr[GR_PPN +: 38];
      newEntry.ed = gr[GR_ED];
      newEntry.key = ii[II_KEY +: 24];
    end
  end

  // Structure number of a slot is its index divided by NS
  genvar gi;
  generate
    for (gi = 0; gi < NE; gi++) begin : g_slot
      tlbf_slot u_slot (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .wrEn(slotWr[gi]),
        .clrEn(slotClr[gi]),
        .wrEntry(newEntry),
        .qVpn(newVpn),
        .qPs(insPs),
        .qRid(newRid),
        .lkVpn(lkVpn),
        .lkRid(lkRid),
        .entry(ent[gi]),
        .overlap(ovl[gi]),
        .hit(hit[gi])
      );
    end
  endgenerate

  // One word per key register above the region registers
  assign keyAddr = (s_ff.addr >= A_PKR) && (s_ff.addr < A_PKR + 8'(4 * NPKR));
  assign keyWr = s_ff.wrPend && keyAddr;

  tlbf_keyfile #(
    .N(NPKR),
    .IW(KW)
  ) u_keys (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wrEn(keyWr),
    .wrIdx(s_ff.addr[2 +: KW]),
    .wrData(hwdata),
    .rdIdx(s_ff.addr[2 +: KW]),
    .rdData(keyRd),
    .qKey(fe.key),
    .qHit(keyHit)
  );

  // First hit among the structures of the requested side
  assign lkInstr = hwdata[LK_INSTR];
  assign lkLegacy = hwdata[LK_LEGACY];
  // Legacy references always check the accessed and dirty bits
  assign lkChkOn = lkLegacy || (lkInstr ? !hwdata[LK_IDIS] : !hwdata[LK_DDIS]);
  always_comb begin
    found = 1'b0;
    fe = '0;
    for (int i = 0; i < NE; i++) begin
      if (!found && hit[i] && (lkInstr == ((i / NS == S_ITC) || (i / NS == S_ITR)))) begin
        found = 1'b1;
        fe = ent[i];
      end
    end
  end

  // Low page bits under a large page come from the looked-up address
  assign pgMask = ~({38{1'b1}} << (fe.ps - PS_MIN));

  // Command decode; codes outside the five defined ones do nothing
  assign cmdOp = hwdata[CMD_OP +: 3];
  assign cmdIns = (cmdOp == OP_ITC_I) || (cmdOp == OP_ITC_D) || (cmdOp == OP_ITR_I) || (cmdOp == OP_ITR_D);
  assign cmdCache = (cmdOp == OP_ITC_I) || (cmdOp == OP_ITC_D);
  assign cmdPurge = (cmdOp == OP_PURGE);

  always_comb begin
    int tcBase;
    int trBase;
    logic side;
    logic [2:0] op;
    logic [2:0] flt;
    nxt_s = s_ff;
    slotWr = '0;
    slotClr = '0;
    op = cmdOp;
    side = (op == OP_ITC_D) || (op == OP_ITR_D);
    tcBase = side ? S_DTC * NS : S_ITC * NS;
    trBase = side ? S_DTR * NS : S_ITR * NS;
    flt = F_NONE;

    // Data phase of a write
    if (s_ff.wrPend) begin
      unique case (s_ff.addr)
        A_GR_LO: nxt_s.grLo = hwdata;
        A_GR_HI: nxt_s.grHi = hwdata;
        A_II_LO: nxt_s.iiLo = hwdata;
        A_II_HI: nxt_s.iiHi = hwdata;
        A_FA_LO: nxt_s.faLo = hwdata;
        A_FA_HI: nxt_s.faHi = hwdata;
        A_LK_LO: nxt_s.lkLo = hwdata;
        A_LK_HI: nxt_s.lkHi = hwdata;
        A_STAT: begin
          if (hwdata[0]) begin
            nxt_s.rsvdFault = 1'b0;
          end
        end
        A_CMD: begin
          if (cmdIns) begin
            if (rsvd) begin
              nxt_s.rsvdFault = 1'b1;
            end else begin
              // Same-side cache entries that overlap go first
              for (int i = 0; i < NS; i++) begin
                slotClr[tcBase + i] = ovl[tcBase + i];
              end
              // Round robin per side; pinned slots are named by software
              if (cmdCache) begin
                slotWr[tcBase + int'(s_ff.tcPtr[side])] = 1'b1;
                nxt_s.tcPtr[side] = s_ff.tcPtr[side] + 1'b1;
              end else begin
                slotWr[trBase + int'(hwdata[CMD_SLOT +: IW])] = 1'b1;
              end
            end
          end else if (cmdPurge) begin
            for (int i = 0; i < NS; i++) begin
              slotClr[S_ITC * NS + i] = ovl[S_ITC * NS + i];
              slotClr[S_DTC * NS + i] = ovl[S_DTC * NS + i];
            end
          end
        end
        A_LK_CTL: begin
          // Fault order: miss, not present, key, access, dirty
          if (!found) begin
            flt = F_MISS;
          end else if (!fe.present) begin
            flt = F_NOTP;
          end else if (!keyHit) begin
            flt = F_KEY;
          end else if (!fe.a && lkChkOn) begin
            flt = F_ACC;
          end else if (!lkInstr && hwdata[LK_STORE] && !fe.d && lkChkOn) begin
            flt = F_DIRTY;
          end
          nxt_s.lkRes = '0;
          nxt_s.lkRes[RES_HIT] = found;
          nxt_s.lkRes[RES_FLT +: 3] = flt;
          // Deferral only means something for instruction entries
          nxt_s.lkRes[RES_ED] = fe.ed && lkInstr && !hwdata[LK_LEGACY];
          nxt_s.lkRes[RES_MA +: 3] = fe.ma;
          nxt_s.lkRes[RES_PL +: 2] = fe.pl;
          nxt_s.lkRes[RES_AR +: 3] = fe.ar;
          nxt_s.lkRes[RES_PS +: 6] = fe.ps;
          nxt_s.lkPpn = 32'((fe.ppn & ~pgMask) | (lkVpn[37:0] & pgMask));
        end
        default: begin
          if (s_ff.addr[7:5] == A_RR[7:5]) begin
            nxt_s.rr[s_ff.addr[4:2]] = hwdata;
          end
        end
      endcase
    end

    // Read data are fetched in a wait state so they come from a flop
    if (s_ff.rdWait) begin
      nxt_s.rdWait = 1'b0;
      // Unmapped offsets read zero
      nxt_s.rdata = '0;
      unique case (s_ff.addr)
        A_GR_LO: nxt_s.rdata = s_ff.grLo;
        A_GR_HI: nxt_s.rdata = s_ff.grHi;
        A_II_LO: nxt_s.rdata = s_ff.iiLo;
        A_II_HI: nxt_s.rdata = s_ff.iiHi;
        A_FA_LO: nxt_s.rdata = s_ff.faLo;
        A_FA_HI: nxt_s.rdata = s_ff.faHi;
        A_LK_LO: nxt_s.rdata = s_ff.lkLo;
        A_LK_HI: nxt_s.rdata = s_ff.lkHi;
        A_STAT: nxt_s.rdata = {31'h0, s_ff.rsvdFault};
        A_LK_RES: nxt_s.rdata = s_ff.lkRes;
        A_LK_PPN: nxt_s.rdata = s_ff.lkPpn;
        default: begin
          if (s_ff.addr[7:5] == A_RR[7:5]) begin
            nxt_s.rdata = s_ff.rr[s_ff.addr[4:2]];
          end else if (keyAddr) begin
            nxt_s.rdata = keyRd;
          end
        end
      endcase
    end else if (hready) begin
      // Address phase; only whole words are expected, hsize is not decoded
      nxt_s.wrPend = hsel && htrans[1] && hwrite;
      nxt_s.rdWait = hsel && htrans[1] && !hwrite;
      nxt_s.addr = {haddr[7:2], 2'b00};
    end
  end

  // Reset clears every register and the lookup result
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Reads stall one cycle for the registered read data; writes never stall
  assign hreadyout = !s_ff.rdWait;
  assign hresp = 1'b0;
  assign hrdata = s_ff.rdata;
endmodule

// ### rtl/tlbf_pkg.sv
// Shared constants and types for the translation insert block.
// Assumes one 40 MHz clock and an AHB-Lite register bus of 32 bits.
package tlbf_pkg;
  // Register byte offsets
  localparam logic [7:0] A_GR_LO = 8'h00;
  localparam logic [7:0] A_GR_HI = 8'h04;
  localparam logic [7:0] A_II_LO = 8'h08;
  localparam logic [7:0] A_II_HI = 8'h0c;
  localparam logic [7:0] A_FA_LO = 8'h10;
  localparam logic [7:0] A_FA_HI = 8'h14;
  localparam logic [7:0] A_CMD = 8'h18;
  localparam logic [7:0] A_STAT = 8'h1c;
  localparam logic [7:0] A_LK_LO = 8'h20;
  localparam logic [7:0] A_LK_HI = 8'h24;
  localparam logic [7:0] A_LK_CTL = 8'h28;
  localparam logic [7:0] A_LK_RES = 8'h2c;
  localparam logic [7:0] A_LK_PPN = 8'h30;
  localparam logic [7:0] A_RR = 8'h40;
  localparam logic [7:0] A_PKR = 8'h60;
  localparam int NUM_RR = 8;
  // Operand fields
  localparam int GR_P = 0;
  localparam int GR_MA = 2;
  localparam int GR_A = 5;
  localparam int GR_D = 6;
  localparam int GR_PL = 7;
  localparam int GR_AR = 9;
  localparam int GR_PPN = 12;
  localparam int GR_RSV = 50;
  localparam int GR_ED = 52;
  localparam int II_RSV = 0;
  localparam int II_PS = 2;
  localparam int II_KEY = 8;
  localparam int VA_VPN = 12;
  localparam int VA_VRN = 61;
  localparam int RR_RSV = 1;
  localparam int RR_RID = 8;
  localparam int PKR_V = 0;
  localparam int PKR_KEY = 8;
  localparam logic [5:0] PS_MIN = 6'h0c;
  // Command and lookup control fields
  localparam int CMD_OP = 0;
  localparam int CMD_SLOT = 4;
  localparam logic [2:0] OP_ITC_I = 3'h1;
  localparam logic [2:0] OP_ITC_D = 3'h2;
  localparam logic [2:0] OP_ITR_I = 3'h3;
  localparam logic [2:0] OP_ITR_D = 3'h4;
  localparam logic [2:0] OP_PURGE = 3'h5;
  localparam int LK_INSTR = 0;
  localparam int LK_STORE = 1;
  localparam int LK_LEGACY = 2;
  localparam int LK_DDIS = 3;
  localparam int LK_IDIS = 4;
  localparam int RES_HIT = 0;
  localparam int RES_FLT = 4;
  localparam int RES_ED = 8;
  localparam int RES_MA = 9;
  localparam int RES_PL = 12;
  localparam int RES_AR = 16;
  localparam int RES_PS = 24;
  localparam logic [2:0] F_NONE = 3'h0;
  localparam logic [2:0] F_MISS = 3'h1;
  localparam logic [2:0] F_NOTP = 3'h2;
  localparam logic [2:0] F_KEY = 3'h3;
  localparam logic [2:0] F_ACC = 3'h4;
  localparam logic [2:0] F_DIRTY = 3'h5;
  // Structure numbers within the slot array
  localparam int S_ITC = 0;
  localparam int S_DTC = 1;
  localparam int S_ITR = 2;
  localparam int S_DTR = 3;
  localparam int NUM_STRUCT = 4;

  typedef struct packed {
    logic valid;
    logic present;
    logic [2:0] ma;
    logic a;
    logic d;
    logic [1:0] pl;
    logic [2:0] ar;
    logic [37:0] ppn;
    logic ed;
    logic [5:0] ps;
    logic [23:0] key;
    logic [51:0] vpn;
    logic [23:0] rid;
  } tlbf_entry_type;
endpackage

// ### rtl/tlbf_slot.sv
// One translation entry with its overlap and lookup match.
// Assumes the caller never writes a page size below the minimum.
`timescale 1ns/10ps
module tlbf_slot
  import tlbf_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Install and purge
  input wire logic wrEn,
  input wire logic clrEn,
  input wire tlbf_entry_type wrEntry,
  // Overlap query
  input wire logic [51:0] qVpn,
  input wire logic [5:0] qPs,
  input wire logic [23:0] qRid,
  // Lookup query
  input wire logic [51:0] lkVpn,
  input wire logic [23:0] lkRid,
  // Results
  output tlbf_entry_type entry,
  output logic overlap,
  output logic hit
);
  tlbf_entry_type ent_ff;
  tlbf_entry_type nxt_ent;
  logic [5:0] bigPs;

  always_comb begin
    nxt_ent = ent_ff;
    if (clrEn) begin
      nxt_ent.valid = 1'b0;
    end
    // Install beats purge of the same slot
    if (wrEn) begin
      nxt_ent = wrEntry;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ent_ff <= '0;
    end else begin
      ent_ff <= nxt_ent;
    end
  end

  // Overlap ignores the page number bits below the larger page
  assign bigPs = (qPs > ent_ff.ps) ? qPs : ent_ff.ps;
  assign overlap = ent_ff.valid && (ent_ff.rid == qRid) &&
                   (((qVpn ^ ent_ff.vpn) >> (bigPs - PS_MIN)) == '0);
  assign hit = ent_ff.valid && (ent_ff.rid == lkRid) &&
               (((lkVpn ^ ent_ff.vpn) >> (ent_ff.ps - PS_MIN)) == '0);
  assign entry = ent_ff;
endmodule

// ### rtl/tlbf_keyfile.sv
// Protection key registers with a bus port and a parallel key search.
// Assumes writes come one at a time from the bus slave.
`timescale 1ns/10ps
module tlbf_keyfile
  import tlbf_pkg::*;
#(
  parameter int N = 4,
  parameter int IW = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register access
  input wire logic wrEn,
  input wire logic [IW-1:0] wrIdx,
  input wire logic [31:0] wrData,
  input wire logic [IW-1:0] rdIdx,
  output logic [31:0] rdData,
  // Key search
  input wire logic [23:0] qKey,
  output logic qHit
);
  typedef struct packed {
    logic [N-1:0][31:0] pkr;
  } tlbf_key_state_type;

  tlbf_key_state_type s_ff;
  tlbf_key_state_type nxt_s;

  always_comb begin
    nxt_s = s_ff;
    if (wrEn) begin
      nxt_s.pkr[wrIdx] = wrData;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  always_comb begin
    qHit = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (s_ff.pkr[i][PKR_V] && (s_ff.pkr[i][PKR_KEY +: 24] == qKey)) begin
        qHit = 1'b1;
      end
    end
  end

  assign rdData = s_ff.pkr[rdIdx];
endmodule

// ### testbench/tlbf_insert_chk.sv
// Checker on the insert block's bus ports.
// Assumes whole-word transfers with hready looped back from hreadyout.
`timescale 1ns/10ps
module tlbf_insert_chk
  import tlbf_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata
);
  logic dpV_ff;
  logic dpW_ff;
  logic [7:0] dpA_ff;
  logic [4:0] lkCtl_ff;
  logic take;
  logic rdEnd;
  logic resRd;
  assign take = hready && hsel && htrans[1];
  assign rdEnd = dpV_ff && !dpW_ff && hreadyout;
  assign resRd = rdEnd && dpA_ff == A_LK_RES;
  // Last lookup control kept so fault codes can be judged
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dpV_ff <= 1'b0;
      dpW_ff <= 1'b0;
      dpA_ff <= 8'h0;
      lkCtl_ff <= 5'h0;
    end else begin
      if (hready) begin
        dpV_ff <= take;
        dpW_ff <= hwrite;
        dpA_ff <= haddr[7:0];
      end
      if (dpV_ff && dpW_ff && hreadyout && dpA_ff == A_LK_CTL) begin
        lkCtl_ff <= hwdata[4:0];
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  rd_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  wr_fast_a: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  resp_ok_a: assert property (hresp == 1'b0)
    else $error("error response seen");
  rd_hold_a: assert property (!(dpV_ff && !dpW_ff) |=> $stable(hrdata))
    else $error("read data moved outside a read");
  stat_bits_a: assert property (rdEnd && dpA_ff == A_STAT |-> hrdata[31:1] == 31'h0)
    else $error("status spare bits set");
  flt_code_a: assert property (resRd |-> hrdata[6:4] <= F_DIRTY)
    else $error("unknown fault code");
  miss_hit_a: assert property (resRd && hrdata[6:4] == F_MISS |-> !hrdata[0])
    else $error("miss reported with hit");
  dirty_load_a: assert property (resRd && (lkCtl_ff[LK_INSTR] || !lkCtl_ff[LK_STORE]) |-> hrdata[6:4] != F_DIRTY)
    else $error("dirty fault on non-store");
  page_min_a: assert property (resRd && hrdata[0] && hrdata[6:4] == F_NONE |-> hrdata[29:24] >= PS_MIN)
    else $error("page size below minimum");
endmodule

bind tlbf_insert tlbf_insert_chk tlbf_insert_chk_i (.clk_sys, .rst_b, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hresp, .hrdata);

// ### testbench/tlbf_master.sv
// Bus master model standing in for the execution pipeline.
// Assumes one slave whose hreadyout is the bus hready.
`timescale 1ns/10ps
module tlbf_master (
  // Clock
  input wire logic clk_sys,
  // Bus
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Released write data is inverted so stale values never look valid
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hwdata <= ~hwdata;
    do @(posedge clk_sys); while (!hready);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (!hready);
    q = hrdata;
  endtask
endmodule

// ### testbench/tlbf_insert_bench.sv
// Bench for the translation insert block, driven over its register bus.
// Assumes the master model and the bound checker.
`timescale 1ns/10ps
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin numErrors++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tlbf_insert_bench
  import tlbf_pkg::*;
;
  localparam logic [63:0] II = 64'h1_2330;
  localparam logic [63:0] VA = 64'h6000_0000_1234_5000;
  localparam logic [63:0] VI = 64'h6000_0000_0000_2000;
  localparam logic [63:0] VR = 64'h6000_0000_0000_a000;
  logic clk_sys, rst_b, hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int numErrors = 0;
  int checksDone = 0;
  tlbf_insert tlbf_insert_i (.clk_sys, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout(hready), .hresp, .hrdata);
  tlbf_master tlbf_master_i (.clk_sys, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    tlbf_master_i.xfer(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    tlbf_master_i.xfer(a, 1'b0, 32'h0, q);
  endtask
  task automatic w64(input logic [7:0] a, input logic [63:0] d);
    wr(a, d[31:0]);
    wr(a + 8'h4, d[63:32]);
  endtask
  task automatic ins(input logic [2:0] op, input logic s, input logic [63:0] gr, ii, fa);
    w64(A_GR_LO, gr);
    w64(A_II_LO, ii);
    w64(A_FA_LO, fa);
    wr(A_CMD, {27'h0, s, 1'b0, op});
  endtask
  task automatic lk(input logic [63:0] va, input logic [4:0] ctl);
    w64(A_LK_LO, va);
    wr(A_LK_CTL, {27'h0, ctl});
    rd(A_LK_RES, r);
  endtask
  task automatic fk(input logic [63:0] va, input logic [4:0] ctl, input logic [2:0] f);
    lk(va, ctl);
    `CHK("fault", f, r[6:4])
  endtask
  // Rejected insert must flag status and leave no entry behind
  task automatic rsv(input logic [63:0] gr, ii, fa);
    ins(OP_ITC_D, 1'b0, gr, ii, fa);
    rd(A_STAT, r);
    `CHK("rsvd", 32'h1, r)
    wr(A_STAT, 32'h1);
    fk(fa, 5'h0, F_MISS);
  endtask
  task automatic closeOut;
    $display("checks %0d errors %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    numErrors++;
    closeOut();
  end
  initial begin
    rst_b = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    fk(64'h0, 5'h0, F_MISS);
    rd(A_STAT, r);
    `CHK("stat", 32'h0, r)
    wr(A_RR + 8'hc, 32'habcdfd);
    wr(A_PKR, 32'h12301);
    ins(OP_ITC_D, 1'b0, 64'hfff0_0000_7777_7b35, II, VA | 64'habc);
    rd(A_GR_HI, r);
    `CHK("gr", 32'hfff0_0000, r)
    lk(VA, 5'h0);
    `CHK("res", 32'h0c05_2a01, r)
    rd(A_LK_PPN, r);
    `CHK("ppn", 32'h77777, r)
    fk(VA, 5'h2, F_DIRTY);
    fk(VA, 5'ha, F_NONE);
    fk(VA ^ 64'h2000_0000_0000_0000, 5'h0, F_MISS);
    wr(A_RR + 8'hc, 32'hee00);
    fk(VA, 5'h0, F_MISS);
    wr(A_RR + 8'hc, 32'habcd00);
    fk(VA, 5'h0, F_NONE);
    ins(OP_ITC_I, 1'b0, 64'h0010_0000_0005_5001, II, VI);
    fk(VI, 5'h1, F_ACC);
    fk(VI, 5'h11, F_NONE);
    `CHK("defer", 1'b1, r[8])
    fk(VI, 5'h15, F_ACC);
    ins(OP_ITC_D, 1'b0, 64'h21, 64'h4_5630, VA + 64'hb000);
    fk(VA + 64'hb000, 5'h0, F_KEY);
    ins(OP_ITC_D, 1'b0, 64'hffff_ffff_ffff_fffe, II, VR - 64'h1000);
    rd(A_STAT, r);
    `CHK("np stat", 32'h0, r)
    fk(VR - 64'h1000, 5'h0, F_NOTP);
    `CHK("np res", 32'h0c00_0021, r)
    wr(A_RR + 8'h14, 32'h2);
    rsv(64'h21, II | 64'h1, VR);
    rsv(64'h21, II | 64'h1_0000_0000, VR);
    rsv(64'h21, 64'h1_232c, VR);
    rsv(64'h0004_0000_0000_0021, II, VR);
    rsv(64'h21, II, 64'ha000_0000_0000_a000);
    ins(OP_ITC_D, 1'b0, 64'h1_1021, II, 64'h6000_0000_0000_7000);
    ins(OP_ITC_D, 1'b0, 64'h2_2021, II | 64'h4, 64'h6000_0000_0000_6000);
    lk(64'h6000_0000_0000_7000, 5'h0);
    `CHK("ps", 6'hd, r[29:24])
    rd(A_LK_PPN, r);
    `CHK("big ppn", 31'h11, r[31:1])
    // A 4K purge at 6000 spares a stale 4K entry at 7000, so a hit there means the insert kept it
    ins(OP_PURGE, 1'b0, 64'h21, II, 64'h6000_0000_0000_6000);
    fk(64'h6000_0000_0000_7000, 5'h0, F_MISS);
    fk(64'h6000_0000_0000_6000, 5'h0, F_MISS);
    fk(VI, 5'h11, F_NONE);
    ins(OP_ITR_I, 1'b0, 64'h21, II, 64'h6000_0000_0000_c000);
    ins(OP_ITR_D, 1'b1, 64'h21, II, 64'h6000_0000_0000_d000);
    fk(64'h6000_0000_0000_c000, 5'h1, F_NONE);
    fk(64'h6000_0000_0000_c000, 5'h0, F_MISS);
    fk(64'h6000_0000_0000_d000, 5'h0, F_NONE);
    fk(64'h6000_0000_0000_d000, 5'h1, F_MISS);
    closeOut();
  end
endmodule
